// >>> hw/msp_pkg.sv
package msp_pkg;

   // ---------------------------------------------------------------
   // Command byte layout and special codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_SPECIAL = 8'hEA;
   localparam logic [7:0] CODE_WR_ENABLE = 8'hE5;
   localparam logic [7:0] CODE_WR_PROTECT = 8'hDC;
   localparam logic [7:0] CODE_CHAN_A = 8'h5A;
   localparam logic [7:0] CODE_CHAN_B = 8'hA5;
   localparam logic [7:0] CODE_CHIP_RESET = 8'h96;
   localparam int CMD_WRITE_BIT = 7;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam int LEN_W = 2;

   // ---------------------------------------------------------------
   // Posted word: kind, address, data
   // ---------------------------------------------------------------
   localparam int POST_W = 1 + ADDR_W + DATA_W;
   localparam logic POST_WRITE = 1'b0;
   localparam logic POST_SPECIAL = 1'b1;
   localparam int FIFO_DEPTH = 32;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int MCLK_PERIOD_NS = 5;
   localparam int WD_TIME_US = 9150;
   localparam int WD_CYCLES = (WD_TIME_US * 1000 + MCLK_PERIOD_NS - 1)
                              / MCLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Register length map reset value: every entry two bytes
   // ---------------------------------------------------------------
   localparam logic [255:0] LEN_MAP_DEFAULT = {128{2'h1}};
   localparam logic [127:0] PROT_MAP_DEFAULT = {128{1'b1}};

endpackage : msp_pkg

// >>> hw/msp_spi_slave.sv
`timescale 1ns/100ps
// What this block does
// [R01] Serial port active only when mode pin high
// [R02] Four wires: select, data in, out, clock
// [R03] Drive out on rising, sample in on falling
// [R04] Host changes its data on rising edges
// [R05] Back-to-back transactions within one select
// [R06] Idle clock beyond watchdog resets the port
// [R07] Command byte: bit7 write, bits 6-0 address
// [R08] 0xEA prefix; E5 unprotects, DC protects
// [R09] 5A selects channel A, A5 channel B
// [R10] Code 96 triggers full chip reset
// [R11] Bits travel most significant first
// [R12] Multi-byte registers go high byte first
// [R13] Read data follows command in same frame
// [R14] Host leaves half-clock gap between bytes
// [R15] Host waits half clock before deselecting
// [R16] Host sends command then data bytes
// [R17] Host enables writes before protected writes
// [R18] Protected registers ignore writes while protected

// ---------------------------------------------------------------
// Posted-word FIFO
// ---------------------------------------------------------------
module msp_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } msp_fifo_st_t;

   msp_fifo_st_t s_r, s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // Flags come straight from the count, so full and empty are exact.
   assign inReady = (s_r.cnt != FULL);
   assign outValid = (s_r.cnt != '0);
   assign outData = mem[s_r.rp];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // Pointer and count update.
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[s_r.wp] <= inData;
      end
   end
endmodule : msp_fifo

// ---------------------------------------------------------------
// Serial slave command port
// ---------------------------------------------------------------
module msp_spi_slave #(
   parameter int WD_CYCLES = msp_pkg::WD_CYCLES,
   parameter int FIFO_DEPTH = msp_pkg::FIFO_DEPTH,
   parameter logic [255:0] LEN_MAP = msp_pkg::LEN_MAP_DEFAULT,
   parameter logic [127:0] PROT_MAP = msp_pkg::PROT_MAP_DEFAULT
) (
   // Clocks and reset
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   // Serial pins
   input wire logic interfaceModePin,
   input wire logic selectLow,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEn_n,
   // Register file read side
   output logic rdReq,
   output logic [msp_pkg::ADDR_W-1:0] rdAddr,
   input wire logic rdValid,
   input wire logic [msp_pkg::DATA_W-1:0] rdData,
   // Register file write side
   output logic wrValid,
   output logic [msp_pkg::ADDR_W-1:0] wrAddr,
   output logic [msp_pkg::DATA_W-1:0] wrData,
   input wire logic wrReady,
   // Chip control
   output logic chanB,
   output logic writeEnabled,
   output logic chipReset,
   output logic postOverrun
);
   localparam int WDW = $clog2(WD_CYCLES + 1);
   localparam logic [WDW-1:0] WD_LIMIT = WDW'(WD_CYCLES);

   typedef enum logic [1:0] {PH_CMD, PH_CODE, PH_WDATA, PH_RDATA} msp_ph_t;
   typedef enum logic {M_IDLE, M_WRITE} msp_mst_t;

   // Falling-edge frame state, cleared at every deselect.
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] bitCnt;
      msp_ph_t ph;
      logic [1:0] left;
      logic [6:0] addr;
      logic [31:0] wdata;
   } msp_fall_t;

   // Falling-edge posting state, kept across frames for the crossing.
   typedef struct packed {
      logic postTog;
      logic [39:0] postWord;
      logic rdTog;
      logic [6:0] rdAddr;
   } msp_post_t;

   // Rising-edge output state.
   typedef struct packed {
      logic [31:0] osh;
      logic out;
   } msp_rise_t;

   // System-clock state.
   typedef struct packed {
      logic [1:0] selS;
      logic [2:0] sclkS;
      logic [1:0] modeS;
      logic [2:0] postS;
      logic [2:0] rdS;
      logic [WDW-1:0] wdCnt;
      logic kill;
      msp_mst_t st;
      logic rdReq;
      logic [6:0] rdAddr;
      logic [31:0] rdWord;
      logic wrValid;
      logic [6:0] wrAddr;
      logic [31:0] wrData;
      logic chanB;
      logic wrEn;
      logic chipReset;
      logic oeN;
      logic overrun;
   } msp_m_t;

   msp_fall_t f_r, f_nxt;
   msp_post_t p_r, p_nxt;
   msp_rise_t r_r, r_nxt;
   msp_m_t m_r, m_nxt;
   logic linkRst_n;
   logic fifoInReady, fifoOutValid, fifoOutReady;
   logic [39:0] fifoOutData;
   logic [7:0] byteIn;

   // Byte length code of an address: bytes minus one.
   function automatic logic [1:0] lenOf(input logic [6:0] a);
      return LEN_MAP[{a, 1'b0} +: 2];
   endfunction : lenOf

   // ---------------------------------------------------------------
   // Link domain
   // ---------------------------------------------------------------

   // Deselect, strap low or watchdog all clear the frame. The clock is
   // idle whenever these act, so release needs no synchroniser.
   assign linkRst_n = rst_n & ~selectLow & m_r.modeS[1] & ~m_r.kill; // [R01] [R02] [R06]
   assign byteIn = {f_r.sh[6:0], serialIn}; // [R11]

   // Falling edge: shift in one bit and decode complete bytes.
   always_comb begin
      f_nxt = f_r;
      p_nxt = p_r;
      f_nxt.sh = byteIn; // [R03] [R04]
      f_nxt.bitCnt = f_r.bitCnt + 1'b1;
      if (f_r.bitCnt == 3'h7) begin
         case (f_r.ph)
            PH_CMD: begin
               f_nxt.addr = byteIn[6:0]; // [R07]
               f_nxt.left = lenOf(byteIn[6:0]);
               if (byteIn == msp_pkg::CMD_SPECIAL) begin
                  f_nxt.ph = PH_CODE; // [R08]
               end else if (byteIn[msp_pkg::CMD_WRITE_BIT]) begin
                  f_nxt.ph = PH_WDATA; // [R16]
               end else begin
                  f_nxt.ph = PH_RDATA; // [R13]
                  p_nxt.rdTog = ~p_r.rdTog;
                  p_nxt.rdAddr = byteIn[6:0];
               end
            end
            PH_CODE: begin
               p_nxt.postTog = ~p_r.postTog;
               p_nxt.postWord = {msp_pkg::POST_SPECIAL, 7'h00, 24'h00_0000,
                                 byteIn};
               f_nxt.ph = PH_CMD; // [R05]
            end
            PH_WDATA: begin
               f_nxt.wdata = {f_r.wdata[23:0], byteIn}; // [R12]
               if (f_r.left == 2'h0) begin
                  p_nxt.postTog = ~p_r.postTog;
                  p_nxt.postWord = {msp_pkg::POST_WRITE, f_r.addr,
                                    f_r.wdata[23:0], byteIn};
                  f_nxt.ph = PH_CMD; // [R05]
                  f_nxt.wdata = '0;
               end else begin
                  f_nxt.left = f_r.left - 1'b1;
               end
            end
            PH_RDATA: begin
               if (f_r.left == 2'h0) begin
                  f_nxt.ph = PH_CMD; // [R05]
               end else begin
                  f_nxt.left = f_r.left - 1'b1;
               end
            end
            default: begin
               f_nxt.ph = PH_CMD;
            end
         endcase
      end
   end

   // Falling-edge frame register.
   always_ff @(negedge sclk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   // Posting register: only a full reset clears it, so a word under
   // transfer survives the deselect that follows its last bit. While the
   // frame is held in reset the bit count stays at zero, so nothing posts.
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         p_r <= '0;
      end else begin
         p_r <= p_nxt;
      end
   end

   // Rising edge: on the first data bit of a read, load the fetched word
   // MSB aligned. The word must have landed by then; the host's gap
   // after the command byte is what gives the fetch its time.
   always_comb begin
      r_nxt = r_r;
      r_nxt.out = 1'b0;
      if (f_r.ph == PH_RDATA) begin
         if (f_r.bitCnt == 3'h0 && f_r.left == lenOf(f_r.addr)) begin
            r_nxt.osh = m_r.rdWord << {~lenOf(f_r.addr), 3'h0}; // [R12]
         end
         r_nxt.out = r_nxt.osh[31]; // [R03] [R11] [R13]
         r_nxt.osh = {r_nxt.osh[30:0], 1'b0};
      end
   end

   // Rising-edge output register.
   always_ff @(posedge sclk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign serialOut = r_r.out;

   // ---------------------------------------------------------------
   // System-clock domain
   // ---------------------------------------------------------------

   // Synchronisers, watchdog, read fetch, drain and special commands.
   always_comb begin
      m_nxt = m_r;
      m_nxt.selS = {m_r.selS[0], selectLow};
      m_nxt.sclkS = {m_r.sclkS[1:0], sclk};
      m_nxt.modeS = {m_r.modeS[0], interfaceModePin};
      m_nxt.postS = {m_r.postS[1:0], p_r.postTog};
      m_nxt.rdS = {m_r.rdS[1:0], p_r.rdTog};
      m_nxt.rdReq = 1'b0;
      m_nxt.chipReset = 1'b0;
      m_nxt.kill = 1'b0;
      m_nxt.oeN = m_r.selS[1] | ~m_r.modeS[1]; // [R01]
      // Count system clocks between rising serial edges in a frame.
      if (m_r.selS[1] || !m_r.modeS[1]) begin
         m_nxt.wdCnt = '0;
      end else if (m_r.sclkS[1] && !m_r.sclkS[2]) begin
         m_nxt.wdCnt = '0;
      end else if (m_r.wdCnt == WD_LIMIT) begin
         m_nxt.kill = 1'b1; // [R06]
         m_nxt.wdCnt = '0;
      end else begin
         m_nxt.wdCnt = m_r.wdCnt + 1'b1;
      end
      // Read request crossing; address is stable until the next toggle.
      if (m_r.rdS[1] != m_r.rdS[2]) begin
         m_nxt.rdReq = 1'b1; // [R13]
         m_nxt.rdAddr = p_r.rdAddr;
      end
      if (rdValid) begin
         m_nxt.rdWord = rdData;
      end
      // A posted word with no room is lost and flagged.
      if (m_r.postS[1] != m_r.postS[2] && !fifoInReady) begin
         m_nxt.overrun = 1'b1;
      end
      case (m_r.st)
         M_IDLE: begin
            if (fifoOutValid) begin
               if (fifoOutData[39] == msp_pkg::POST_WRITE) begin
                  if (m_r.wrEn || !PROT_MAP[fifoOutData[38:32]]) begin
                     m_nxt.st = M_WRITE; // [R18]
                     m_nxt.wrValid = 1'b1;
                     m_nxt.wrAddr = fifoOutData[38:32];
                     m_nxt.wrData = fifoOutData[31:0];
                  end
               end else begin
                  case (fifoOutData[7:0])
                     msp_pkg::CODE_WR_ENABLE: m_nxt.wrEn = 1'b1; // [R08] [R17]
                     msp_pkg::CODE_WR_PROTECT: m_nxt.wrEn = 1'b0; // [R08]
                     msp_pkg::CODE_CHAN_A: m_nxt.chanB = 1'b0; // [R09]
                     msp_pkg::CODE_CHAN_B: m_nxt.chanB = 1'b1; // [R09]
                     msp_pkg::CODE_CHIP_RESET: m_nxt.chipReset = 1'b1; // [R10]
                     default: m_nxt.chipReset = 1'b0;
                  endcase
               end
            end
         end
         M_WRITE: begin
            if (wrReady) begin
               m_nxt.wrValid = 1'b0;
               m_nxt.st = M_IDLE;
            end
         end
         default: begin
            m_nxt.st = M_IDLE;
            m_nxt.wrValid = 1'b0;
         end
      endcase
   end

   // System-clock state register.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         m_r <= '0;
         m_r.selS <= 2'h3;
         m_r.oeN <= 1'b1;
      end else begin
         m_r <= m_nxt;
      end
   end

   // The drain stalls while a write waits for the register file.
   assign fifoOutReady = (m_r.st == M_IDLE);

   msp_fifo #(
      .WIDTH(msp_pkg::POST_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .inValid(m_r.postS[1] != m_r.postS[2]),
      .inReady(fifoInReady),
      .inData(p_r.postWord),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   assign serialOutEn_n = m_r.oeN;
   assign rdReq = m_r.rdReq;
   assign rdAddr = m_r.rdAddr;
   assign wrValid = m_r.wrValid;
   assign wrAddr = m_r.wrAddr;
   assign wrData = m_r.wrData;
   assign chanB = m_r.chanB;
   assign writeEnabled = m_r.wrEn;
   assign chipReset = m_r.chipReset;
   assign postOverrun = m_r.overrun;
endmodule : msp_spi_slave

// >>> sim/msp_checker.sv
`timescale 1ns/100ps
// ----------
// Port checker
// ----------
module msp_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial pins
   input wire logic interfaceModePin,
   input wire logic selectLow,
   input wire logic serialOut,
   input wire logic serialOutEn_n,
   // Register side
   input wire logic rdReq,
   input wire logic [msp_pkg::ADDR_W-1:0] rdAddr,
   input wire logic wrValid,
   input wire logic [msp_pkg::ADDR_W-1:0] wrAddr,
   input wire logic [msp_pkg::DATA_W-1:0] wrData,
   input wire logic wrReady,
   // Chip control
   input wire logic chanB,
   input wire logic writeEnabled,
   input wire logic chipReset,
   input wire logic postOverrun
);
   // All checks live in the system clock domain.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   write_hold_a:
      assert property (wrValid && !wrReady |=> wrValid &&
         $stable(wrAddr) && $stable(wrData)) else $error("write dropped");
   read_pulse_a:
      assert property (rdReq |=> !rdReq) else $error("rdReq too long");
   read_addr_a:
      assert property (rdReq |=> $stable(rdAddr)) else $error("rdAddr moved");
   reset_pulse_a:
      assert property (chipReset |=> !chipReset) else $error("reset long");
   reset_alone_a:
      assert property (chipReset |-> $stable(chanB) && $stable(writeEnabled))
         else $error("flags moved on reset");
   overrun_sticky_a:
      assert property (postOverrun |=> postOverrun) else $error("overrun lost");
   idle_float_a:
      assert property (selectLow [*4] |-> serialOutEn_n)
         else $error("driving while deselected");
   mode_float_a:
      assert property (!interfaceModePin [*4] |-> serialOutEn_n)
         else $error("driving in other mode");
   out_quiet_a:
      assert property (selectLow [*2] |-> !serialOut)
         else $error("serialOut busy while idle");
endmodule : msp_checker

bind msp_spi_slave msp_checker u_chk (.mclk(mclk), .rst_n(rst_n),
   .interfaceModePin(interfaceModePin), .selectLow(selectLow),
   .serialOut(serialOut), .serialOutEn_n(serialOutEn_n), .rdReq(rdReq),
   .rdAddr(rdAddr), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
   .wrReady(wrReady), .chanB(chanB), .writeEnabled(writeEnabled),
   .chipReset(chipReset), .postOverrun(postOverrun));

// >>> sim/msp_host_model.sv
`timescale 1ns/100ps
// ----------
// Serial host model
// ----------
module msp_host_model #(
   parameter int HALF = 24
) (
   // Host driven pins
   output logic sclk,
   output logic selectLow,
   output logic serialIn,
   // Device driven pin and its enable
   input wire logic serialOut,
   input wire logic serialOutEn_n
);
   logic [7:0] rxByte;

   // The clock stands still low between frames.
   initial begin
      sclk = 1'b0;
      selectLow = 1'b1;
      serialIn = 1'b1;
      rxByte = 8'h00;
   end

   // Select falls; no edge until the device has settled.
   task automatic openFrame();
      selectLow = 1'b0;
      #(4*HALF);
   endtask : openFrame

   // Bits go out MSB first on rises and are taken on falls.
   task automatic xferByte(input logic [7:0] tx, input int nBits,
                           input int gapNs);
      for (int i = 7; i > 7 - nBits; i--) begin
         sclk = 1'b1;
         serialIn = tx[i];
         #HALF;
         sclk = 1'b0;
         // An undriven line has no pull, so here it reads as serialOut inverted.
         rxByte[i] = serialOutEn_n ? ~serialOut : serialOut;
         #HALF;
      end
      #gapNs;
   endtask : xferByte

   // Deselect after the hold; a released data line must not look valid.
   task automatic closeFrame();
      #HALF;
      selectLow = 1'b1;
      serialIn = ~serialIn;
      #(4*HALF);
   endtask : closeFrame
endmodule : msp_host_model

// >>> sim/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
   nMismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
   logic mclk, rst_n, sclk, modePin, selectLow, serialIn, serialOut, outEn_n;
   logic rdReq, rdValid, wrValid, wrReady, chanB, writeEnabled;
   logic chipReset, postOverrun, stall;
   logic [6:0] rdAddr, wrAddr;
   logic [31:0] rdData, wrData, rdWord;
   logic [38:0] expQ[$];
   logic [38:0] e;
   int seed = 32'h3c19_8a48;
   int nMismatch = 0;
   int samplesChecked = 0;
   int cycles = 0;
   int resetSeen = 0;

   msp_spi_slave #(.WD_CYCLES(200)) uut (.mclk(mclk), .rst_n(rst_n),
      .sclk(sclk), .interfaceModePin(modePin), .selectLow(selectLow),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutEn_n(outEn_n),
      .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
      .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
      .wrReady(wrReady), .chanB(chanB), .writeEnabled(writeEnabled),
      .chipReset(chipReset), .postOverrun(postOverrun));
   msp_host_model host (.sclk(sclk), .selectLow(selectLow),
      .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn_n(outEn_n));

   // ----------
   // Clock, register-side responder and watchers
   // ----------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Read data answers rdReq; the write side stalls at random.
   always @(negedge mclk) begin
      rdValid <= rdReq;
      rdData <= rdReq ? rdWord : 32'h0000_0000;
      wrReady <= !stall && $random(seed) % 2;
   end

   // Each accepted write is matched with the oldest note.
   always @(posedge mclk) begin
      cycles++;
      if (chipReset) resetSeen++;
      if (rst_n && wrValid && wrReady) begin
         if (expQ.size() != 0) begin
            e = expQ.pop_front();
            `CHK("write", e, {wrAddr, wrData})
         end else begin
            `CHK("write", 1'b0, 1'b1)
         end
      end
      if (cycles == 60000) begin
         nMismatch++;
         giveVerdict();
      end
   end

   // ----------
   // Host-side transactions and the verdict
   // ----------
   task automatic wrCmd(input logic [6:0] a, input bit keep);
      logic [15:0] d;
      d = $random(seed);
      if (keep) expQ.push_back({a, 16'h0000, d});
      host.xferByte({1'b1, a}, 8, 24);
      host.xferByte(d[15:8], 8, 24);
      host.xferByte(d[7:0], 8, 24);
   endtask : wrCmd

   task automatic rdCmd(input logic [6:0] a);
      rdWord = $random(seed);
      host.xferByte({1'b0, a}, 8, 120);
      `CHK("rdAddr", a, rdAddr)
      host.xferByte($random(seed), 8, 24);
      `CHK("rd hi", rdWord[15:8], host.rxByte)
      host.xferByte($random(seed), 8, 24);
      `CHK("rd lo", rdWord[7:0], host.rxByte)
   endtask : rdCmd

   task automatic spec(input logic [7:0] code);
      host.xferByte(msp_pkg::CMD_SPECIAL, 8, 24);
      host.xferByte(code, 8, 24);
      repeat (10) @(negedge mclk);
   endtask : spec

   task automatic giveVerdict();
      $display("mismatches %0d, checks %0d", nMismatch, samplesChecked);
      if (nMismatch == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : giveVerdict

   // ----------
   // Main sequence
   // ----------
   initial begin
      {rst_n, stall, rdWord} = '0;
      modePin = 1'b1;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      repeat (5) @(negedge mclk);
      // One frame holds many back-to-back transactions.
      host.openFrame();
      spec(msp_pkg::CODE_WR_ENABLE);
      `CHK("wrEn", 1'b1, writeEnabled)
      wrCmd(7'h02, 1'b1);
      rdCmd(7'h05);
      wrCmd(7'h7f, 1'b1);
      spec(msp_pkg::CODE_CHAN_B);
      `CHK("chanB", 1'b1, chanB)
      spec(8'h3c);
      `CHK("chanB", 1'b1, chanB)
      spec(msp_pkg::CODE_CHAN_A);
      `CHK("chanB", 1'b0, chanB)
      spec(msp_pkg::CODE_WR_PROTECT);
      `CHK("wrEn", 1'b0, writeEnabled)
      wrCmd(7'h03, 1'b0);
      spec(msp_pkg::CODE_CHIP_RESET);
      `CHK("reset", 1, resetSeen)
      host.closeFrame();
      // A stalled clock mid-byte must clear the frame.
      host.openFrame();
      host.xferByte(8'hff, 3, 0);
      repeat (300) @(negedge mclk);
      spec(msp_pkg::CODE_WR_ENABLE);
      `CHK("wrEn", 1'b1, writeEnabled)
      wrCmd(7'h04, 1'b1);
      host.closeFrame();
      // Traffic in the other pin mode is ignored.
      modePin = 1'b0;
      repeat (5) @(negedge mclk);
      host.openFrame();
      wrCmd(7'h06, 1'b0);
      `CHK("outEn_n", 1'b1, outEn_n)
      host.closeFrame();
      modePin = 1'b1;
      // Fill the buffer past full, then drain it.
      // Room is the buffer depth plus the word parked at the write port.
      stall = 1'b1;
      host.openFrame();
      for (int i = 0; i < 40; i++)
         wrCmd(7'h10 + 7'(i), i <= msp_pkg::FIFO_DEPTH);
      host.closeFrame();
      `CHK("overrun", 1'b1, postOverrun)
      stall = 1'b0;
      for (int i = 0; i < 3000 && expQ.size() != 0; i++) @(negedge mclk);
      `CHK("drained", 0, expQ.size())
      repeat (100) @(negedge mclk);
      giveVerdict();
   end
endmodule : tb
